// *** core/event_store.v ***
// small memory holding queued touch events, registered read port
`timescale 1ns/1ns
module event_store #(
  parameter WIDTH = 5,
  parameter DEPTH = 30,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // ========================================================================
  // storage
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// *** core/touch_scan_defs.vh ***
// register map, field layout and timing constants of the touch scan block
`ifndef TOUCH_SCAN_DEFS_VH
`define TOUCH_SCAN_DEFS_VH

// ==========================================================================
// register offsets
`define REG_EVENT_QUEUE     8'h00
`define REG_FAULT_CODE      8'h01
`define REG_LIVE_STATE      8'h02
`define REG_SLEEP_SETUP     8'h08

// ==========================================================================
// field positions
`define Q_MORE_BIT          7
`define Q_EMPTY_BIT         6
`define Q_OVF_BIT           5
`define Q_PRESS_BIT         4
`define LIVE_TOUCH_BIT      4
`define SETUP_IDLE_MSB      7
`define SETUP_IDLE_LSB      5
`define SETUP_SLEEP_MSB     4
`define SETUP_SLEEP_LSB     0

// ==========================================================================
// reset values and codes
`define SETUP_RESET         8'h00
`define FAULT_NONE          2'h0
`define FAULT_TO_GND        2'h1
`define FAULT_TO_SUPPLY     2'h2
`define QUEUE_DEPTH         30
`define TICK_OFFSET         9'h005
`define NORMAL_MULT         2
`define IDLE_MULT           20'h00006
`define I2C_ADDR_DEFAULT    7'h2a

// ==========================================================================
// timing: the schedule counts in 8 ms units of the primary clock
`define CLK_MHZ             250
`define BASE_UNIT_MS        8
`define BASE_UNIT_CYCLES    (`BASE_UNIT_MS * 1000 * `CLK_MHZ)

`endif

// *** core/touch_scan_report.v ***
// scan scheduling, event queue, fault and live status behind an i2c slave
`timescale 1ns/1ns
`include "touch_scan_defs.vh"
module touch_scan_report #(
  parameter        [21:0] UNIT_CYCLES = `BASE_UNIT_CYCLES,
  parameter        [6:0]  DEV_ADDR    = `I2C_ADDR_DEFAULT
) (
  input  wire       CLK,
  input  wire       RST_N,
  input  wire       SCL_I,
  input  wire       SDA_I,
  output wire       SDA_O,
  output reg        SDA_OE,
  input  wire       SCAN_ENABLE_BIT,
  input  wire       DUTY_CYCLE_ENABLE_N,
  input  wire [7:0] TICK_SETTING,
  input  wire [7:0] ACQUISITION_SAMPLE_FACTOR,
  input  wire       TOUCH_ACTIVE,
  input  wire [2:0] LIVE_ELECTRODE,
  input  wire       TOUCH_EVENT,
  input  wire       EVENT_PRESS,
  input  wire [2:0] EVENT_ELECTRODE,
  input  wire       SHORT_DETECT,
  input  wire [1:0] SHORT_KIND,
  output reg        SCAN_STROBE,
  output wire       SCAN_ALLOWED,
  output reg        SLEEP_PERIOD,
  output reg        DATA_AVAIL_EVENT,
  output reg        FAULT_EVENT,
  output wire [7:0] SLEEP_SCHEDULE_SETUP
);

  localparam ST_IDLE  = 4'h0;
  localparam ST_ADDR  = 4'h1;
  localparam ST_ACK_A = 4'h2;
  localparam ST_PTR   = 4'h3;
  localparam ST_ACK_P = 4'h4;
  localparam ST_WDATA = 4'h5;
  localparam ST_ACK_W = 4'h6;
  localparam ST_RDATA = 4'h7;
  localparam ST_RACK  = 4'h8;
  localparam [4:0] LAST_SLOT = `QUEUE_DEPTH - 1;
  localparam [4:0] FULL_CNT  = `QUEUE_DEPTH;

  // ========================================================================
  // pin synchronisers
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  wire      scl_s = scl_sync_reg[1];
  wire      scl_p = scl_sync_reg[2];
  wire      sda_s = sda_sync_reg[1];
  wire      sda_p = sda_sync_reg[2];
  wire      scl_rise = scl_s & ~scl_p;
  wire      scl_fall = ~scl_s & scl_p;
  wire      bus_start = scl_s & scl_p & sda_p & ~sda_s;
  wire      bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

  always @(posedge CLK) begin
    if (!RST_N) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
    end
  end

  assign SDA_O = 1'b0;

  // ========================================================================
  // registers and queue state
  reg  [7:0] setup_reg;
  reg  [7:0] ptr_reg;
  reg  [1:0] fault_reg;
  reg  [4:0] wr_ptr_reg;
  reg  [4:0] rd_ptr_reg;
  reg  [4:0] count_reg;
  reg        ovf_reg;
  wire [4:0] head_entry;
  wire       q_empty = (count_reg == 5'h00);
  wire       q_full  = (count_reg == FULL_CNT);
  wire       run_mode  = SCAN_ENABLE_BIT;
  wire       duty_mode = SCAN_ENABLE_BIT & ~DUTY_CYCLE_ENABLE_N;

  // strobes from the i2c engine
  reg        pop_req;
  reg        clr_req;
  reg        fault_wr_req;
  reg        setup_wr_req;
  reg        q_access;
  reg  [7:0] wr_byte;

  wire push_ok = TOUCH_EVENT & (~q_full | clr_req);
  wire do_pop  = pop_req & ~q_empty & ~clr_req;
  wire [4:0] wr_ptr_inc = (wr_ptr_reg == LAST_SLOT) ? 5'h00 : wr_ptr_reg + 5'h01;
  wire [4:0] rd_ptr_inc = (rd_ptr_reg == LAST_SLOT) ? 5'h00 : rd_ptr_reg + 5'h01;
  wire [4:0] wr_slot    = clr_req ? rd_ptr_reg : wr_ptr_reg;

  event_store #(
    .WIDTH (5),
    .DEPTH (`QUEUE_DEPTH),
    .AW    (5)
  ) u_store (
    .clk     (CLK),
    .wr_en   (push_ok),
    .wr_addr (wr_slot),
    .wr_data ({EVENT_PRESS, 1'b0, EVENT_ELECTRODE}),
    .rd_addr (rd_ptr_reg),
    .rd_data (head_entry)
  );

  always @(posedge CLK) begin
    if (!RST_N) begin
      wr_ptr_reg <= 5'h00;
      rd_ptr_reg <= 5'h00;
      count_reg  <= 5'h00;
      ovf_reg    <= 1'b0;
    end else if (clr_req) begin
      // a write flushes; an event in the same cycle lands in the fresh queue
      wr_ptr_reg <= push_ok ? rd_ptr_inc : rd_ptr_reg;
      count_reg  <= push_ok ? 5'h01 : 5'h00;
      ovf_reg    <= 1'b0;
    end else begin
      if (push_ok) begin
        wr_ptr_reg <= wr_ptr_inc;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_inc;
      end
      if (push_ok & ~do_pop) begin
        count_reg <= count_reg + 5'h01;
      end else if (do_pop & ~push_ok) begin
        count_reg <= count_reg - 5'h01;
      end
      if (TOUCH_EVENT & q_full) begin
        ovf_reg <= 1'b1;
      end
    end
  end

  // ========================================================================
  // fault and setup registers
  always @(posedge CLK) begin
    if (!RST_N) begin
      fault_reg <= `FAULT_NONE;
      setup_reg <= `SETUP_RESET;
    end else begin
      if (SHORT_DETECT & (fault_reg == `FAULT_NONE)) begin
        fault_reg <= SHORT_KIND;
      end else if (fault_wr_req & ~run_mode) begin
        fault_reg <= `FAULT_NONE;
      end
      if (setup_wr_req) begin
        setup_reg <= wr_byte;
      end
    end
  end

  assign SLEEP_SCHEDULE_SETUP = setup_reg;
  assign SCAN_ALLOWED = run_mode & (fault_reg == `FAULT_NONE);

  // ========================================================================
  // events toward the surrounding unit
  reg empty_d_reg;
  reg fault_nz_d_reg;
  wire fault_nz = (fault_reg != `FAULT_NONE);

  always @(posedge CLK) begin
    if (!RST_N) begin
      empty_d_reg      <= 1'b1;
      fault_nz_d_reg   <= 1'b0;
      DATA_AVAIL_EVENT <= 1'b0;
      FAULT_EVENT      <= 1'b0;
    end else begin
      empty_d_reg    <= q_empty;
      fault_nz_d_reg <= fault_nz;
      if (empty_d_reg & ~q_empty) begin
        DATA_AVAIL_EVENT <= 1'b1;
      end else if (q_access) begin
        DATA_AVAIL_EVENT <= 1'b0;
      end
      if (fault_nz & ~fault_nz_d_reg) begin
        FAULT_EVENT <= 1'b1;
      end else if (~fault_nz) begin
        FAULT_EVENT <= 1'b0;
      end
    end
  end

  // ========================================================================
  // read multiplexer
  reg [7:0] rd_value;
  always @* begin
    case (ptr_reg)
      `REG_EVENT_QUEUE: rd_value = {(count_reg > 5'h01), q_empty, ovf_reg,
                                    q_empty ? 5'h00 : head_entry};
      `REG_FAULT_CODE:  rd_value = {6'h00, fault_reg};
      `REG_LIVE_STATE:  rd_value = {3'h0, TOUCH_ACTIVE, 1'b0,
                                    TOUCH_ACTIVE ? LIVE_ELECTRODE : 3'h0};
      `REG_SLEEP_SETUP: rd_value = setup_reg;
      default:          rd_value = 8'h00;
    endcase
  end

  // ========================================================================
  // i2c slave engine
  reg [3:0] state_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg       byte_done_reg;
  reg       rw_reg;
  reg       nack_reg;

  always @(posedge CLK) begin
    if (!RST_N) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
      rw_reg        <= 1'b0;
      nack_reg      <= 1'b0;
      SDA_OE        <= 1'b0;
      pop_req       <= 1'b0;
      clr_req       <= 1'b0;
      fault_wr_req  <= 1'b0;
      setup_wr_req  <= 1'b0;
      q_access      <= 1'b0;
      wr_byte       <= 8'h00;
    end else begin
      pop_req      <= 1'b0;
      clr_req      <= 1'b0;
      fault_wr_req <= 1'b0;
      setup_wr_req <= 1'b0;
      q_access     <= 1'b0;
      if (bus_stop) begin
        state_reg <= ST_IDLE;
        SDA_OE    <= 1'b0;
      end else if (bus_start) begin
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= 3'h0;
        byte_done_reg <= 1'b0;
        SDA_OE        <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_PTR ||
            state_reg == ST_WDATA) begin
          shift_reg     <= {shift_reg[6:0], sda_s};
          bit_cnt_reg   <= bit_cnt_reg + 3'h1;
          byte_done_reg <= (bit_cnt_reg == 3'h7);
        end else if (state_reg == ST_RACK) begin
          nack_reg <= sda_s;
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (byte_done_reg) begin
              byte_done_reg <= 1'b0;
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg    <= shift_reg[0];
                SDA_OE    <= 1'b1;
                state_reg <= ST_ACK_A;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK_A, ST_RACK: begin
            if (state_reg == ST_RACK && nack_reg) begin
              SDA_OE    <= 1'b0;
              state_reg <= ST_IDLE;
            end else if (state_reg == ST_RACK || rw_reg) begin
              // load outgoing byte; a queue read pops its entry here
              shift_reg   <= rd_value;
              SDA_OE      <= ~rd_value[7];
              bit_cnt_reg <= 3'h0;
              state_reg   <= ST_RDATA;
              if (ptr_reg == `REG_EVENT_QUEUE) begin
                pop_req  <= 1'b1;
                q_access <= 1'b1;
              end
            end else begin
              SDA_OE      <= 1'b0;
              bit_cnt_reg <= 3'h0;
              state_reg   <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (byte_done_reg) begin
              byte_done_reg <= 1'b0;
              ptr_reg       <= shift_reg;
              SDA_OE        <= 1'b1;
              state_reg     <= ST_ACK_P;
            end
          end
          ST_ACK_P, ST_ACK_W: begin
            SDA_OE      <= 1'b0;
            bit_cnt_reg <= 3'h0;
            state_reg   <= ST_WDATA;
          end
          ST_WDATA: begin
            if (byte_done_reg) begin
              byte_done_reg <= 1'b0;
              wr_byte       <= shift_reg;
              SDA_OE        <= 1'b1;
              state_reg     <= ST_ACK_W;
              // the live status register ignores writes
              case (ptr_reg)
                `REG_EVENT_QUEUE: begin
                  clr_req  <= 1'b1;
                  q_access <= 1'b1;
                end
                `REG_FAULT_CODE:  fault_wr_req <= 1'b1;
                `REG_SLEEP_SETUP: setup_wr_req <= 1'b1;
                default:          wr_byte <= shift_reg;
              endcase
            end
          end
          ST_RDATA: begin
            if (bit_cnt_reg == 3'h7) begin
              SDA_OE    <= 1'b0;
              state_reg <= ST_RACK;
            end else begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              SDA_OE      <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
          end
          default: begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // scan schedule arithmetic
  wire [2:0]  idle_factor  = setup_reg[`SETUP_IDLE_MSB:`SETUP_IDLE_LSB];
  wire [4:0]  sleep_factor = setup_reg[`SETUP_SLEEP_MSB:`SETUP_SLEEP_LSB];
  wire        lp_allowed   = (idle_factor != 3'h0) & (sleep_factor != 5'h00);
  wire [8:0]  tick_sum     = {1'b0, TICK_SETTING} + `TICK_OFFSET;
  wire [5:0]  tick_fact    = tick_sum[8:3] + 6'h01;
  wire [13:0] base_units   = tick_fact * ACQUISITION_SAMPLE_FACTOR;
  wire [15:0] normal_units = {base_units, 2'b00};
  wire [20:0] sleep_units  = normal_units * sleep_factor;
  wire [19:0] idle_units   = base_units * idle_factor * `IDLE_MULT;
  wire [20:0] period_units = SLEEP_PERIOD ? sleep_units : {5'h00, normal_units};

  // ========================================================================
  // 8 ms unit timer and scan scheduler
  reg  [21:0] unit_cnt_reg;
  reg  [20:0] scan_cnt_reg;
  reg  [19:0] idle_cnt_reg;
  reg         duty_d_reg;
  wire        unit_tick = (unit_cnt_reg == UNIT_CYCLES - 22'h000001);
  wire        activity  = TOUCH_EVENT | TOUCH_ACTIVE;
  wire        wake      = TOUCH_ACTIVE | (TOUCH_EVENT & EVENT_PRESS);

  always @(posedge CLK) begin
    if (!RST_N) begin
      unit_cnt_reg <= 22'h000000;
      scan_cnt_reg <= 21'h000000;
      idle_cnt_reg <= 20'h00000;
      duty_d_reg   <= 1'b0;
      SLEEP_PERIOD <= 1'b0;
      SCAN_STROBE  <= 1'b0;
    end else begin
      duty_d_reg   <= duty_mode;
      SCAN_STROBE  <= 1'b0;
      unit_cnt_reg <= unit_tick ? 22'h000000 : unit_cnt_reg + 22'h000001;
      if (!duty_mode || !duty_d_reg) begin
        // outside duty-cycled run, and on entering it, start fresh
        scan_cnt_reg <= 21'h000000;
        idle_cnt_reg <= 20'h00000;
        SLEEP_PERIOD <= 1'b0;
        SCAN_STROBE  <= unit_tick & SCAN_ALLOWED;
      end else if (SLEEP_PERIOD && (wake || !lp_allowed)) begin
        SLEEP_PERIOD <= 1'b0;
        scan_cnt_reg <= 21'h000000;
        idle_cnt_reg <= 20'h00000;
      end else begin
        if (activity) begin
          idle_cnt_reg <= 20'h00000;
        end else if (unit_tick && !SLEEP_PERIOD && lp_allowed) begin
          if (idle_cnt_reg + 20'h00001 >= idle_units) begin
            SLEEP_PERIOD <= 1'b1;
            scan_cnt_reg <= 21'h000000;
            idle_cnt_reg <= 20'h00000;
          end else begin
            idle_cnt_reg <= idle_cnt_reg + 20'h00001;
          end
        end
        if (unit_tick) begin
          if (scan_cnt_reg + 21'h000001 >= period_units) begin
            scan_cnt_reg <= 21'h000000;
            SCAN_STROBE  <= SCAN_ALLOWED;
          end else begin
            scan_cnt_reg <= scan_cnt_reg + 21'h000001;
          end
        end
      end
    end
  end

endmodule

// *** verif/i2c_host_model.sv ***
// i2c master standing in for the host processor
`timescale 1ns/1ns
module i2c_host_model #(
  parameter [6:0] ADDR = 7'h2a
) (
  output reg       scl,
  output reg       sda_low,
  input  wire      sda,
  output reg       rd_valid,
  output reg [7:0] rd_byte
);
  // half period of the 48 ns bus clock
  integer h;
  reg     ack;
  initial begin
    h = 24;
    scl = 1'b1;
    sda_low = 1'b0;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
  end
  // data moves an eighth of a period after the low edge, well clear
  // of the device's own output update after that edge
  task bitx(input reg drv, output reg smp);
    #(h / 4) sda_low = ~drv;
    #(h - h / 4) scl = 1'b1;
    #(h / 2) smp = sda;
    #(h / 2) scl = 1'b0;
  endtask
  task xbyte(input [7:0] d, input reg last, output [7:0] q);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(last, ack);
  endtask
  task start;
    #(h / 4) sda_low = 1'b0;
    #(h - h / 4) scl = 1'b1;
    #h sda_low = 1'b1;
    #h scl = 1'b0;
  endtask
  task stop;
    #(h / 4) sda_low = 1'b1;
    #(h - h / 4) scl = 1'b1;
    #h sda_low = 1'b0;
    #h;
  endtask
  task write_reg(input [7:0] p, input [7:0] d);
    reg [7:0] q;
    start;
    xbyte({ADDR, 1'b0}, 1'b1, q);
    xbyte(p, 1'b1, q);
    xbyte(d, 1'b1, q);
    stop;
  endtask
  // the pointer does not advance, so n bytes re-read one place
  task read_reg(input [7:0] p, input integer n);
    reg [7:0] q;
    start;
    xbyte({ADDR, 1'b0}, 1'b1, q);
    xbyte(p, 1'b1, q);
    start;
    xbyte({ADDR, 1'b1}, 1'b1, q);
    repeat (n) begin
      n = n - 1;
      xbyte(8'hff, n == 0, q);
      // the byte settles a step before its strobe rises
      rd_byte = q;
      #1 rd_valid = 1'b1;
      #1 rd_valid = 1'b0;
    end
    stop;
  endtask
endmodule

// *** verif/touch_scan_report_assertions.sv ***
// concurrent checks on the ports of the touch scan report block
`timescale 1ns/1ns
module touch_scan_report_assertions #(
  parameter [21:0] UNIT_CYCLES = 22'h000014
) (
  input wire       CLK,
  input wire       RST_N,
  input wire       SCAN_ENABLE_BIT,
  input wire       DUTY_CYCLE_ENABLE_N,
  input wire       TOUCH_ACTIVE,
  input wire       TOUCH_EVENT,
  input wire       SHORT_DETECT,
  input wire       SCAN_STROBE,
  input wire       SCAN_ALLOWED,
  input wire       SLEEP_PERIOD,
  input wire       DATA_AVAIL_EVENT,
  input wire       FAULT_EVENT,
  input wire [7:0] SLEEP_SCHEDULE_SETUP
);
  reg  [23:0] gap_reg;
  wire        duty = SCAN_ENABLE_BIT & ~DUTY_CYCLE_ENABLE_N;
  wire        lp_off = SLEEP_SCHEDULE_SETUP[7:5] == 3'h0 ||
                       SLEEP_SCHEDULE_SETUP[4:0] == 5'h00;
  // ==========================================================
  // cycles since the last strobe; one spare cycle of slack
  // because the first unit after reset may start one edge late
  always @(posedge CLK) begin
    if (!RST_N || SCAN_STROBE)
      gap_reg <= 24'h000000;
    else
      gap_reg <= gap_reg + 24'h000001;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  a_strobe_gap: assert property (SCAN_STROBE |->
    gap_reg >= UNIT_CYCLES - 22'h2) else $error("strobes too close");
  a_fault_blocks: assert property (!SCAN_ALLOWED &&
    $past(!SCAN_ALLOWED) |-> !SCAN_STROBE) else $error("strobe in fault");
  a_fault_halts: assert property ($rose(FAULT_EVENT) |->
    !SCAN_ALLOWED) else $error("scan allowed with fault");
  a_allowed_run: assert property (SCAN_ALLOWED |->
    SCAN_ENABLE_BIT) else $error("scan allowed in stop mode");
  a_sleep_mode: assert property (!duty |-> ##[1:2]
    !SLEEP_PERIOD) else $error("sleeping outside duty mode");
  a_sleep_factor: assert property (lp_off |-> ##[1:2]
    !SLEEP_PERIOD) else $error("sleeping with zero factor");
  a_touch_wakes: assert property (SLEEP_PERIOD && TOUCH_ACTIVE
    |-> ##[1:2] !SLEEP_PERIOD) else $error("touch did not wake");
  a_sleep_entry: assert property ($rose(SLEEP_PERIOD) |->
    $past(duty && !TOUCH_ACTIVE)) else $error("bad sleep entry");
  a_data_cause: assert property ($rose(DATA_AVAIL_EVENT) |->
    $past(TOUCH_EVENT) || $past(TOUCH_EVENT, 2) ||
    $past(TOUCH_EVENT, 3)) else $error("data event without push");
  a_fault_cause: assert property ($rose(FAULT_EVENT) |->
    $past(SHORT_DETECT) || $past(SHORT_DETECT, 2) ||
    $past(SHORT_DETECT, 3)) else $error("fault event without short");
  c_sleep: cover property ($rose(SLEEP_PERIOD));
  c_fault: cover property ($rose(FAULT_EVENT));
  c_data: cover property ($rose(DATA_AVAIL_EVENT));
endmodule

bind touch_scan_report touch_scan_report_assertions #(
  .UNIT_CYCLES(UNIT_CYCLES)) chk (.CLK(CLK), .RST_N(RST_N),
  .SCAN_ENABLE_BIT(SCAN_ENABLE_BIT),
  .DUTY_CYCLE_ENABLE_N(DUTY_CYCLE_ENABLE_N),
  .TOUCH_ACTIVE(TOUCH_ACTIVE), .TOUCH_EVENT(TOUCH_EVENT),
  .SHORT_DETECT(SHORT_DETECT), .SCAN_STROBE(SCAN_STROBE),
  .SCAN_ALLOWED(SCAN_ALLOWED), .SLEEP_PERIOD(SLEEP_PERIOD),
  .DATA_AVAIL_EVENT(DATA_AVAIL_EVENT), .FAULT_EVENT(FAULT_EVENT),
  .SLEEP_SCHEDULE_SETUP(SLEEP_SCHEDULE_SETUP));

// *** verif/touch_scan_report_tb.sv ***
// self-checking bench for the touch scan report block
`timescale 1ns/1ns
module touch_scan_report_tb;
  localparam [21:0] UNIT = 22'h000014;
  localparam [6:0]  ADDR = 7'h2a; // arbitrary bus address
  reg        clk, rst_n, run, dce_n, touch, tev, tpress, sdet;
  reg  [7:0] tick, samp, rd_byte;
  reg  [2:0] live_e, te;
  reg  [1:0] skind;
  wire       scl, host_low, sda_oe, sda_o, rd_valid;
  wire       strobe, allowed, sleep, dav, fev;
  wire [7:0] setup;
  wire       sda = ~(host_low | (sda_oe & ~sda_o));
  integer    errors, checks, seed, i, k, c, nu, iu;
  reg  [7:0] q_exp[$];
  reg  [7:0] q_msk[$];
  reg  [4:0] ev[0:29];
  touch_scan_report #(.UNIT_CYCLES(UNIT), .DEV_ADDR(ADDR)) dut (
    .CLK(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .SCAN_ENABLE_BIT(run),
    .DUTY_CYCLE_ENABLE_N(dce_n), .TICK_SETTING(tick),
    .ACQUISITION_SAMPLE_FACTOR(samp), .TOUCH_ACTIVE(touch),
    .LIVE_ELECTRODE(live_e), .TOUCH_EVENT(tev), .EVENT_PRESS(tpress),
    .EVENT_ELECTRODE(te), .SHORT_DETECT(sdet), .SHORT_KIND(skind),
    .SCAN_STROBE(strobe), .SCAN_ALLOWED(allowed), .SLEEP_PERIOD(sleep),
    .DATA_AVAIL_EVENT(dav), .FAULT_EVENT(fev),
    .SLEEP_SCHEDULE_SETUP(setup));
  i2c_host_model #(.ADDR(ADDR)) host (.scl(scl), .sda_low(host_low),
    .sda(sda), .rd_valid(rd_valid), .rd_byte(rd_byte));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  task summarize;
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cmp_val(input string nm, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task cmp_byte(input [7:0] exp, input [7:0] msk, input [7:0] got);
    checks = checks + 1;
    if ((got & msk) !== (exp & msk)) begin
      errors = errors + 1;
      $display("[FAIL] read byte exp %0h got %0h", exp, got);
    end
  endtask
  task note(input [7:0] e, input [7:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
  endtask
  task tk;
    @(posedge clk);
    #1;
  endtask
  task push_evt(input reg p, input [2:0] e);
    tk;
    tev = 1'b1;
    tpress = p;
    te = e;
    tk;
    tev = 1'b0;
  endtask
  task short(input [1:0] k2);
    tk;
    sdet = 1'b1;
    skind = k2;
    tk;
    sdet = 1'b0;
  endtask
  // cycles from the last seen strobe to the next, minus one
  task gap(output integer n);
    n = 0;
    tk;
    while (strobe !== 1'b1 && n < 20000) begin
      tk;
      n = n + 1;
    end
    if (n >= 20000) begin
      errors = errors + 1;
      summarize;
    end
  endtask
  always @(posedge rd_valid) begin
    if (q_exp.size() == 0)
      cmp_val("spare read", 0, 1);
    else
      cmp_byte(q_exp.pop_front(), q_msk.pop_front(), rd_byte);
  end
  // ==========================================================
  initial begin
    {rst_n, run, touch, tev, tpress, sdet, live_e, te, skind} = 0;
    {dce_n, tick, samp} = {1'b1, 8'h00, 8'h01};
    {errors, checks, seed} = {32'd0, 32'd0, 32'd69};
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) tk;
    touch = 1'b1;
    live_e = $random(seed);
    note(8'h00, 8'hff);
    host.read_reg(8'h08, 1);
    host.write_reg(8'h02, 8'hff);
    note({4'h1, 1'b0, live_e}, 8'hff);
    host.read_reg(8'h02, 1);
    tk;
    touch = 1'b0;
    note(8'h00, 8'hff);
    host.read_reg(8'h02, 1);
    note(8'h40, 8'he0);
    host.read_reg(8'h00, 1);
    for (i = 0; i < 31; i = i + 1) begin
      k = $random(seed);
      push_evt(k[3], k[2:0]);
      if (i < 30)
        ev[i] = {k[3], 1'b0, k[2:0]};
    end
    repeat (3) tk;
    cmp_val("data event", 1, dav);
    for (i = 0; i < 30; i = i + 1)
      note({i < 29, 2'b01, ev[i]}, 8'hff);
    note(8'h60, 8'he0);
    host.read_reg(8'h00, 31);
    cmp_val("data event", 0, dav);
    push_evt(1'b1, 3'h7);
    push_evt(1'b0, 3'h0);
    host.write_reg(8'h00, $random(seed));
    note(8'h40, 8'he0);
    host.read_reg(8'h00, 1);
    push_evt(1'b0, 3'h5);
    note(8'h05, 8'hff);
    note(8'h40, 8'he0);
    host.read_reg(8'h00, 2);
    for (k = 1; k < 3; k = k + 1) begin
      tk;
      run = 1'b1;
      short(k[1:0]);
      short(2'h3 - k[1:0]);
      repeat (3) tk;
      cmp_val("fault event", 1, fev);
      cmp_val("scan allowed", 0, allowed);
      host.write_reg(8'h01, 8'h00);
      note({6'h00, k[1:0]}, 8'hff);
      host.read_reg(8'h01, 1);
      tk;
      run = 1'b0;
      host.write_reg(8'h01, 8'h00);
      note(8'h00, 8'hff);
      host.read_reg(8'h01, 1);
    end
    tick = 8'({$random(seed)} % 27);
    samp = 8'({$random(seed)} % 3 + 1);
    nu = ((tick + 5) / 8 + 1) * samp * 4;
    iu = ((tick + 5) / 8 + 1) * samp * 3 * 6;
    host.write_reg(8'h08, 8'h62);
    note(8'h62, 8'hff);
    host.read_reg(8'h08, 1);
    cmp_val("setup port", 8'h62, setup);
    tk;
    {run, dce_n} = 2'b10;
    c = 0;
    while (sleep !== 1'b1 && c < 20000) begin
      tk;
      c = c + 1;
    end
    if (c >= 20000) begin
      errors = errors + 1;
      summarize;
    end
    cmp_val("idle time", 1, c > (iu - 1) * UNIT && c <= (iu + 1) * UNIT);
    gap(c);
    gap(c);
    cmp_val("sleep period", nu * 2 * UNIT, c + 1);
    touch = 1'b1;
    repeat (3) tk;
    cmp_val("sleep after touch", 0, sleep);
    touch = 1'b0;
    gap(c);
    gap(c);
    cmp_val("normal period", nu * UNIT, c + 1);
    dce_n = 1'b1;
    gap(c);
    gap(c);
    cmp_val("plain run period", UNIT, c + 1);
    host.write_reg(8'h08, 8'h60);
    tk;
    dce_n = 1'b0;
    repeat ((iu + 2) * UNIT) tk;
    cmp_val("sleep zero factor", 0, sleep);
    cmp_val("notes left", 0, q_exp.size());
    summarize;
  end
endmodule
